/* File: rtl/mag_map.svh */
// register offsets, field positions, reset values and timing counts of the address/hash slice
`ifndef MAG_MAP_SVH
`define MAG_MAP_SVH

// register indices; the byte address on the bus is four times the index
`define MAG_IDX_ADDR_HIGH 6'h02
`define MAG_IDX_ADDR_LOW 6'h03
`define MAG_IDX_HASH_UPPER 6'h04
`define MAG_IDX_HASH_LOWER 6'h05
`define MAG_IDX_PHY_ACC 6'h06
`define MAG_IDX_PHY_DATA 6'h07
`define MAG_IDX_FILTER_CTRL 6'h0A

// management access and filter control register fields
`define MAG_ACC_BUSY 0
`define MAG_ACC_WRITE 1
`define MAG_ACC_REG_LSB 6
`define MAG_ACC_PHY_LSB 11
`define MAG_FILT_ACCEPT_ALL 0

// reset values
`define MAG_RST_ADDR_LOW 32'h0FFFFFFF
`define MAG_RST_ADDR_HIGH 16'h0FFF
`define MAG_RST_HASH 32'h00000000
`define MAG_RST_PHY_DATA 16'h0000

// eeprom byte addresses that carry the station address
`define MAG_EE_FIRST 8'h01
`define MAG_EE_LAST 8'h06

// management frame layout and timing
`define MAG_PREAMBLE 32'hFFFFFFFF
`define MAG_TA_BIT 46
`define MAG_CLK_PERIOD_NS 40
`define MAG_MDC_HALF_NS 200
`define MAG_MDC_HALF_CYC ((`MAG_MDC_HALF_NS + `MAG_CLK_PERIOD_NS - 1) / `MAG_CLK_PERIOD_NS)

`endif

/* File: rtl/mag_pkg.sv */
// types shared by the address/hash/management slice
package mag_pkg;

  // one filter lookup from the receive path
  typedef struct packed {
    logic valid;
    logic multicast;
    logic [5:0] hash_index;
  } mag_rx_query_type;

  // filter answer, one cycle after the lookup
  typedef struct packed {
    logic valid;
    logic accept;
  } mag_rx_verdict_type;

  // one management cycle request
  typedef struct packed {
    logic write;
    logic [4:0] phy_address;
    logic [4:0] register_index;
    logic [15:0] wdata;
  } mag_mgmt_req_type;

  typedef enum logic {MDIO_IDLE, MDIO_RUN} mag_mdio_state_type;

endpackage : mag_pkg

/* File: rtl/mag_mdio.sv */
// serial management frame engine towards the integrated phy
`include "mag_map.svh"

module mag_mdio #(
  parameter int HALF_CYC = `MAG_MDC_HALF_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request and answer
  input wire logic start,
  input mag_pkg::mag_mgmt_req_type req,
  output logic done,
  output logic [15:0] rdata,
  // management pins
  output logic mdc,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic mdio_in
);
  import mag_pkg::*;

  mag_mdio_state_type state_reg;
  logic [15:0] div_reg;
  logic [63:0] frame_reg;
  logic [5:0] bit_reg;
  logic [15:0] rx_reg;
  logic write_reg;

  // half-period enable of the management clock
  wire tick = (div_reg == 16'(HALF_CYC - 1));
  wire rising = (state_reg == MDIO_RUN) & tick & ~mdc;
  wire falling = (state_reg == MDIO_RUN) & tick & mdc;
  wire last_bit = (bit_reg == 6'd63);
  // a read gives the pin away from the turnaround on
  wire keep_drive = write_reg | (bit_reg < 6'(`MAG_TA_BIT - 1));
  wire [63:0] frame_init = {`MAG_PREAMBLE, 2'b01, req.write ? 2'b01 : 2'b10,
                            req.phy_address, req.register_index,
                            req.write ? 2'b10 : 2'b00, req.write ? req.wdata : 16'h0000};

  // frame sequencer: bits leave on the falling edge, input is sampled on the rising one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= MDIO_IDLE;
      div_reg <= 16'h0000;
      frame_reg <= 64'h0000000000000000;
      bit_reg <= 6'h00;
      rx_reg <= 16'h0000;
      write_reg <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
      mdc <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_reg)
        MDIO_IDLE: begin
          div_reg <= 16'h0000;
          if (start) begin
            frame_reg <= frame_init;
            bit_reg <= 6'h00;
            write_reg <= req.write;
            mdio_out <= frame_init[63];
            mdio_oe <= 1'b1;
            state_reg <= MDIO_RUN;
          end
        end
        MDIO_RUN: begin
          div_reg <= tick ? 16'h0000 : div_reg + 16'h0001;
          if (rising) begin
            mdc <= 1'b1;
            rx_reg <= {rx_reg[14:0], mdio_in};
          end
          if (falling) begin
            mdc <= 1'b0;
            if (last_bit) begin
              state_reg <= MDIO_IDLE;
              done <= 1'b1;
              rdata <= rx_reg;
              mdio_oe <= 1'b0;
              mdio_out <= 1'b0;
            end else begin
              bit_reg <= bit_reg + 6'h01;
              frame_reg <= {frame_reg[62:0], 1'b0};
              mdio_out <= frame_reg[62];
              mdio_oe <= keep_drive;
            end
          end
        end
        default: state_reg <= MDIO_IDLE;
      endcase
    end
  end

endmodule : mag_mdio

/* File: rtl/mag_regs.sv */
// station address, group hash filter and phy management registers behind apb
`include "mag_map.svh"

module mag_regs #(
  parameter int MDC_HALF = `MAG_MDC_HALF_CYC
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // eeprom loader
  input wire logic EE_BYTE_VALID,
  input wire logic [7:0] EE_BYTE_ADDR,
  input wire logic [7:0] EE_BYTE_DATA,
  input wire logic EE_LOAD_DONE,
  // receive filter
  input mag_pkg::mag_rx_query_type RX_QUERY,
  output mag_pkg::mag_rx_verdict_type RX_VERDICT,
  output logic [47:0] STATION_ADDRESS,
  // phy management pins
  output logic MDC,
  output logic MDIO_OUT,
  output logic MDIO_OE,
  input wire logic MDIO_IN
);
  import mag_pkg::*;

  logic [1:0] rst_sync_reg;
  logic [47:0] station_address_reg;
  logic [47:0] station_address_next;
  logic [31:0] group_hash_table_upper_reg;
  logic [31:0] group_hash_table_lower_reg;
  logic accept_all_group_frames_reg;
  logic [4:0] phy_address_reg;
  logic [4:0] phy_register_index_reg;
  logic phy_write_select_reg;
  logic phy_access_busy_reg;
  logic [15:0] phy_management_data_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  mag_rx_verdict_type verdict_reg;
  logic mgmt_done;
  logic [15:0] mgmt_rdata;
  mag_mgmt_req_type mgmt_req;

  // reset release through two flops; the rest of the slice uses the released copy
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  wire rst_n = rst_sync_reg[1];

  // apb decode; no wait states, so every access phase completes at once
  wire setup_phase = PSEL & ~PENABLE;
  wire apb_write = PSEL & PENABLE & PWRITE;
  wire [5:0] reg_idx = PADDR[7:2];
  wire aligned = (PADDR[1:0] == 2'b00);
  wire hit_high = aligned & (reg_idx == `MAG_IDX_ADDR_HIGH);
  wire hit_low = aligned & (reg_idx == `MAG_IDX_ADDR_LOW);
  wire hit_upper = aligned & (reg_idx == `MAG_IDX_HASH_UPPER);
  wire hit_lower = aligned & (reg_idx == `MAG_IDX_HASH_LOWER);
  wire hit_acc = aligned & (reg_idx == `MAG_IDX_PHY_ACC);
  wire hit_data = aligned & (reg_idx == `MAG_IDX_PHY_DATA);
  wire hit_filt = aligned & (reg_idx == `MAG_IDX_FILTER_CTRL);
  wire hit_any = hit_high | hit_low | hit_upper | hit_lower | hit_acc | hit_data | hit_filt;

  // host writes to the address are held off while the loader still owns it
  wire host_addr_open = EE_LOAD_DONE;
  wire ee_loading = EE_BYTE_VALID & ~EE_LOAD_DONE;

  // per-byte station address update: loader first, then host
  for (genvar b = 0; b < 6; b++) begin : g_addr_byte
    wire ee_hit = ee_loading & (EE_BYTE_ADDR == `MAG_EE_FIRST + 8'(b));
    wire host_hit = apb_write & host_addr_open & ((b < 4) ? hit_low : hit_high);
    assign station_address_next[8*b +: 8] = ee_hit ? EE_BYTE_DATA :
                                            host_hit ? PWDATA[8*(b%4) +: 8] :
                                            station_address_reg[8*b +: 8];
  end

  // station address storage; first wire byte sits in bits 7:0
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      station_address_reg <= {`MAG_RST_ADDR_HIGH, `MAG_RST_ADDR_LOW};
    end else begin
      station_address_reg <= station_address_next;
    end
  end
  assign STATION_ADDRESS = station_address_reg;

  // hash halves and the accept-all control bit
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      group_hash_table_upper_reg <= `MAG_RST_HASH;
      group_hash_table_lower_reg <= `MAG_RST_HASH;
      accept_all_group_frames_reg <= 1'b0;
    end else begin
      if (apb_write & hit_upper) group_hash_table_upper_reg <= PWDATA;
      if (apb_write & hit_lower) group_hash_table_lower_reg <= PWDATA;
      if (apb_write & hit_filt) accept_all_group_frames_reg <= PWDATA[`MAG_FILT_ACCEPT_ALL];
    end
  end

  // lookup: msb picks the half, low five bits the bit within it
  wire [63:0] hash_table = {group_hash_table_upper_reg, group_hash_table_lower_reg};
  wire table_bit = hash_table[RX_QUERY.hash_index];
  wire verdict_accept = accept_all_group_frames_reg | table_bit;

  // verdict registered so the receive path sees a clean one-cycle answer
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      verdict_reg <= '0;
    end else begin
      verdict_reg.valid <= RX_QUERY.valid & RX_QUERY.multicast;
      verdict_reg.accept <= RX_QUERY.valid & RX_QUERY.multicast & verdict_accept;
    end
  end
  assign RX_VERDICT = verdict_reg;

  // management access: writes while busy are dropped, so the running cycle cannot be disturbed
  wire acc_write = apb_write & hit_acc & ~phy_access_busy_reg;
  wire mgmt_start = acc_write & PWDATA[`MAG_ACC_BUSY];
  wire data_write = apb_write & hit_data & ~phy_access_busy_reg;

  // access register fields; reserved bits are simply not stored
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      phy_address_reg <= 5'h00;
      phy_register_index_reg <= 5'h00;
      phy_write_select_reg <= 1'b0;
    end else if (acc_write) begin
      phy_address_reg <= PWDATA[`MAG_ACC_PHY_LSB +: 5];
      phy_register_index_reg <= PWDATA[`MAG_ACC_REG_LSB +: 5];
      phy_write_select_reg <= PWDATA[`MAG_ACC_WRITE];
    end
  end

  // busy is set by software and held until the engine reports the end
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      phy_access_busy_reg <= 1'b0;
    end else if (mgmt_start) begin
      phy_access_busy_reg <= 1'b1;
    end else if (mgmt_done) begin
      phy_access_busy_reg <= 1'b0;
    end
  end

  // data register: host value for writes, phy value at the end of reads
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      phy_management_data_reg <= `MAG_RST_PHY_DATA;
    end else if (mgmt_done & ~phy_write_select_reg) begin
      phy_management_data_reg <= mgmt_rdata;
    end else if (data_write) begin
      phy_management_data_reg <= PWDATA[15:0];
    end
  end

  // request built from the freshly written access fields and the held data
  assign mgmt_req.write = PWDATA[`MAG_ACC_WRITE];
  assign mgmt_req.phy_address = PWDATA[`MAG_ACC_PHY_LSB +: 5];
  assign mgmt_req.register_index = PWDATA[`MAG_ACC_REG_LSB +: 5];
  assign mgmt_req.wdata = phy_management_data_reg;

  // serial frame engine on the management pins
  mag_mdio #(
    .HALF_CYC(MDC_HALF)
  ) u_mdio (
    .clk(MCLK),
    .rst_n(rst_n),
    .start(mgmt_start),
    .req(mgmt_req),
    .done(mgmt_done),
    .rdata(mgmt_rdata),
    .mdc(MDC),
    .mdio_out(MDIO_OUT),
    .mdio_oe(MDIO_OE),
    .mdio_in(MDIO_IN)
  );

  // read view of each register; reserved bits read zero
  wire [31:0] acc_view = {16'h0000, phy_address_reg, phy_register_index_reg, 4'h0,
                          phy_write_select_reg, phy_access_busy_reg};
  wire [31:0] rd_data_next = hit_high ? {16'h0000, station_address_reg[47:32]} :
                             hit_low ? station_address_reg[31:0] :
                             hit_upper ? group_hash_table_upper_reg :
                             hit_lower ? group_hash_table_lower_reg :
                             hit_acc ? acc_view :
                             hit_data ? {16'h0000, phy_management_data_reg} :
                             hit_filt ? {31'h00000000, accept_all_group_frames_reg} :
                             32'h00000000;

  // read data and error are caught in the setup cycle so they leave a flop
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      prdata_reg <= rd_data_next;
      pslverr_reg <= ~hit_any;
    end
  end
  assign PRDATA = prdata_reg;
  assign PSLVERR = pslverr_reg & PSEL & PENABLE;
  assign PREADY = 1'b1;

  // checks on the slice, all in the core clock domain
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!rst_n);

  property p_low_write;
    apb_write & hit_low & EE_LOAD_DONE & ~ee_loading |=> STATION_ADDRESS[31:0] == $past(PWDATA);
  endproperty
  a_low_write: assert property (p_low_write)
    else $error("low station address did not take the host write");

  property p_ee_low;
    ee_loading & (EE_BYTE_ADDR == 8'h02) |=> STATION_ADDRESS[15:8] == $past(EE_BYTE_DATA);
  endproperty
  a_ee_low: assert property (p_ee_low)
    else $error("eeprom byte 0x02 did not land in address bits 15:8");

  property p_ee_high;
    ee_loading & (EE_BYTE_ADDR == 8'h06) |=> STATION_ADDRESS[47:40] == $past(EE_BYTE_DATA);
  endproperty
  a_ee_high: assert property (p_ee_high)
    else $error("eeprom byte 0x06 did not land in upper address bits 15:8");

  property p_host_locked;
    apb_write & hit_low & ~EE_LOAD_DONE & ~EE_BYTE_VALID |=> $stable(STATION_ADDRESS);
  endproperty
  a_host_locked: assert property (p_host_locked)
    else $error("host changed the station address during initialisation");

  property p_hash_pick;
    RX_QUERY.valid & RX_QUERY.multicast & ~accept_all_group_frames_reg
      |=> RX_VERDICT.valid && RX_VERDICT.accept == $past(hash_table[RX_QUERY.hash_index]);
  endproperty
  a_hash_pick: assert property (p_hash_pick)
    else $error("filter verdict does not follow the selected hash bit");

  property p_pass_all;
    RX_QUERY.valid & RX_QUERY.multicast & accept_all_group_frames_reg |=> RX_VERDICT.accept;
  endproperty
  a_pass_all: assert property (p_pass_all)
    else $error("multicast frame rejected while accept-all is set");

  property p_top_bit;
    RX_QUERY.valid & RX_QUERY.multicast & (RX_QUERY.hash_index == 6'h3F)
      & ~accept_all_group_frames_reg |=> RX_VERDICT.accept == $past(group_hash_table_upper_reg[31]);
  endproperty
  a_top_bit: assert property (p_top_bit)
    else $error("index 11111 in the upper half did not pick upper bit 31");

  // write access, one idle cycle, then the setup cycle of the read-back
  property p_hash_write;
    apb_write & hit_upper ##2 (PSEL & ~PENABLE & ~PWRITE & hit_upper)
      |=> PRDATA == $past(PWDATA, 3);
  endproperty
  a_hash_write: assert property (p_hash_write)
    else $error("upper hash half did not read back its written value");

  property p_busy_start;
    mgmt_start |=> phy_access_busy_reg ##1 (phy_access_busy_reg & ~mgmt_done)[*8];
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("busy not set and held after a start write");

  property p_busy_clear;
    mgmt_done |=> ~phy_access_busy_reg;
  endproperty
  a_busy_clear: assert property (p_busy_clear)
    else $error("busy not cleared when the management cycle ended");

  property p_index_kept;
    mgmt_start |=> phy_register_index_reg == $past(PWDATA[10:6])
      && phy_write_select_reg == $past(PWDATA[1]);
  endproperty
  a_index_kept: assert property (p_index_kept)
    else $error("register index or direction not captured at start");

  property p_read_result;
    mgmt_done & ~phy_write_select_reg |=> phy_management_data_reg == $past(mgmt_rdata);
  endproperty
  a_read_result: assert property (p_read_result)
    else $error("phy read value not placed in the data register");

  property p_data_hold;
    phy_access_busy_reg & ~mgmt_done |=> $stable(phy_management_data_reg);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("data register changed while a management cycle ran");

  property p_reserved_zero;
    PSEL & ~PENABLE & hit_acc |=> PRDATA[31:16] == 16'h0000 && PRDATA[5:2] == 4'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved access register bits read non-zero");

  property p_no_verdict;
    RX_QUERY.valid & ~RX_QUERY.multicast |=> ~RX_VERDICT.valid;
  endproperty
  a_no_verdict: assert property (p_no_verdict)
    else $error("non-multicast query produced a filter verdict");

  property p_high_write;
    apb_write & hit_high & EE_LOAD_DONE & ~ee_loading
      |=> STATION_ADDRESS[47:32] == $past(PWDATA[15:0]);
  endproperty
  a_high_write: assert property (p_high_write)
    else $error("upper station address did not take the host write");

  // main scenarios
  c_phy_read: cover property (mgmt_done & ~phy_write_select_reg);
  c_phy_write: cover property (mgmt_done & phy_write_select_reg);
  c_hash_accept: cover property (RX_VERDICT.valid & RX_VERDICT.accept & ~accept_all_group_frames_reg);
  c_ee_load: cover property (ee_loading ##[1:20] EE_LOAD_DONE);

endmodule : mag_regs

/* File: verification/mag_phy_model.sv */
// phy-side model of the serial management port: a 32-entry register file
module mag_phy_model (
  // management pins as seen from the phy
  input wire logic mdc,
  input wire logic rst_n,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  output logic mdio_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [32];
  logic [31:0] sh_reg;
  logic [31:0] nx;
  logic [15:0] rword;
  logic rd_op;
  logic drv;
  logic dval;
  int cnt;
  // pull-up holds the line high whenever nobody drives it
  assign mdio_in = mdio_oe ? mdio_out : (drv ? dval : 1'b1);
  assign nx = {sh_reg[30:0], mdio_in};
  // distinct contents per register so a wrong index shows up
  initial begin
    for (int i = 0; i < 32; i++) begin
      mem[i] = 16'hA500 + 16'(i);
    end
  end
  // bits taken on rising mdc; count wraps once per 64-bit frame
  always @(posedge mdc or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      rd_op <= 1'b0;
    end else begin
      sh_reg <= nx;
      cnt <= (cnt == 63) ? 0 : cnt + 1;
      if (cnt == 45) begin
        rd_op <= (nx[11:10] == 2'b10);
        rword <= mem[nx[4:0]];
      end
      if (cnt == 63 && nx[29:28] == 2'b01) begin
        mem[nx[22:18]] <= nx[15:0];
      end
    end
  end
  // read data leaves on falling mdc so it is settled at the next rising edge
  always @(negedge mdc or negedge rst_n) begin
    if (!rst_n) begin
      drv <= 1'b0;
    end else begin
      drv <= rd_op && cnt >= 47;
      dval <= (cnt >= 48) ? rword[63 - cnt] : 1'b0;
    end
  end
endmodule : mag_phy_model

/* File: verification/tb.sv */
// bench: apb tests of address, hash filter and management registers
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mag_pkg::*;
  localparam int HALF = 1;
  // bench-driven inputs
  logic MCLK = 1'b0;
  logic RESET_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h00000000;
  logic EE_BYTE_VALID = 1'b0;
  logic [7:0] EE_BYTE_ADDR = 8'h00;
  logic [7:0] EE_BYTE_DATA = 8'h00;
  logic EE_LOAD_DONE = 1'b0;
  mag_rx_query_type RX_QUERY = '0;
  // design outputs and bench state
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, MDC, MDIO_OUT, MDIO_OE, MDIO_IN;
  mag_rx_verdict_type RX_VERDICT;
  logic [47:0] STATION_ADDRESS;
  logic [31:0] rd;
  logic err;
  logic [7:0] ee [8] = '{8'h00, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9A, 8'hBC, 8'h77};
  logic [5:0] hix [5] = '{6'h00, 6'h3F, 6'h20, 6'h1F, 6'h01};
  logic [4:0] hexp = 5'h03;
  int n_fail = 0;
  int n_tests = 0;
  always #20 MCLK = ~MCLK;
  mag_regs #(.MDC_HALF(HALF)) mag_regs_i (.MCLK(MCLK), .RESET_N(RESET_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .EE_BYTE_VALID(EE_BYTE_VALID),
    .EE_BYTE_ADDR(EE_BYTE_ADDR), .EE_BYTE_DATA(EE_BYTE_DATA), .EE_LOAD_DONE(EE_LOAD_DONE),
    .RX_QUERY(RX_QUERY), .RX_VERDICT(RX_VERDICT), .STATION_ADDRESS(STATION_ADDRESS),
    .MDC(MDC), .MDIO_OUT(MDIO_OUT), .MDIO_OE(MDIO_OE), .MDIO_IN(MDIO_IN));
  mag_phy_model mag_phy_model_i (.mdc(MDC), .rst_n(RESET_N), .mdio_out(MDIO_OUT),
    .mdio_oe(MDIO_OE), .mdio_in(MDIO_IN));
  // one comparison, counted, reported at once on a difference
  task automatic check(input string n, input logic [47:0] seen, input logic [47:0] e);
    n_tests++;
    if (seen !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, seen);
    end
  endtask : check
  task automatic print_verdict();
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  // one apb transfer; an idle cycle after it keeps two drives out of one time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    // only the watchdog ends a wait for the slave
    do begin
      @(posedge MCLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK);
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h00000000);
    check(n, rd, e);
  endtask : rdc
  // one filter lookup; the verdict is looked at in the cycle after it
  task automatic query(input logic [5:0] ix, input logic mc, input logic [1:0] e);
    RX_QUERY <= '{valid: 1'b1, multicast: mc, hash_index: ix};
    @(posedge MCLK);
    RX_QUERY <= '0;
    @(negedge MCLK);
    check("verdict", RX_VERDICT, e);
    @(posedge MCLK);
  endtask : query
  // start a management cycle with reserved bits set, see busy held, poll it down
  task automatic mgmt(input logic w, input logic [4:0] ix);
    logic [31:0] e;
    int k;
    e = {16'h0000, 5'h01, ix, 4'h0, w, 1'b1};
    k = 0;
    apb(1'b1, 8'h18, e | 32'hFFFF003C);
    apb(1'b0, 8'h18, 32'h00000000);
    check("acc_busy", rd, e);
    while (rd[0] !== 1'b0 && k < 200) begin
      apb(1'b0, 8'h18, 32'h00000000);
      k++;
    end
    check("acc_done", rd, e & 32'hFFFFFFFE);
  endtask : mgmt
  // watchdog: the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge MCLK);
    n_fail++;
    print_verdict();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge MCLK);
    RESET_N <= 1'b1;
    repeat (3) @(posedge MCLK);
    rdc(8'h0C, 32'h0FFFFFFF, "addr_low_rst");
    rdc(8'h10, 32'h00000000, "hash_up_rst");
    rdc(8'h14, 32'h00000000, "hash_lo_rst");
    rdc(8'h18, 32'h00000000, "acc_rst");
    // a host write before the loader has finished must be refused
    apb(1'b1, 8'h0C, 32'h11111111);
    rdc(8'h0C, 32'h0FFFFFFF, "addr_low_locked");
    // wire order 12-34-56-78-9A-BC, then one byte outside the address field
    for (int i = 1; i <= 7; i++) begin
      EE_BYTE_VALID <= 1'b1;
      EE_BYTE_ADDR <= 8'(i);
      EE_BYTE_DATA <= ee[i];
      @(posedge MCLK);
    end
    EE_BYTE_VALID <= 1'b0;
    EE_LOAD_DONE <= 1'b1;
    @(posedge MCLK);
    check("station", STATION_ADDRESS, 48'hBC9A78563412);
    rdc(8'h0C, 32'h78563412, "addr_low_ee");
    rdc(8'h08, 32'h0000BC9A, "addr_high_ee");
    apb(1'b1, 8'h0C, 32'hA5A55A5A);
    rdc(8'h0C, 32'hA5A55A5A, "addr_low_wr");
    apb(1'b1, 8'h08, 32'hFFFF1234);
    rdc(8'h08, 32'h00001234, "addr_high_wr");
    // table edges: lower bit 0 and upper bit 31 set, neighbours clear
    apb(1'b1, 8'h14, 32'h00000001);
    apb(1'b1, 8'h10, 32'h80000000);
    rdc(8'h10, 32'h80000000, "hash_up_wr");
    for (int i = 0; i < 5; i++) begin
      query(hix[i], 1'b1, {1'b1, hexp[i]});
    end
    query(6'h3F, 1'b0, 2'b00);
    apb(1'b1, 8'h28, 32'h00000001);
    rdc(8'h28, 32'h00000001, "filt_rd");
    query(6'h20, 1'b1, 2'b11);
    apb(1'b1, 8'h28, 32'h00000000);
    apb(1'b0, 8'h40, 32'h00000000);
    check("unmapped_err", {rd, 15'h0000, err}, 48'h000000000001);
    // phy write, then reads of another register and of the written one
    apb(1'b1, 8'h1C, 32'h00005AC3);
    mgmt(1'b1, 5'h03);
    check("phy_mem", mag_phy_model_i.mem[3], 48'h5AC3);
    rdc(8'h1C, 32'h00005AC3, "data_kept");
    mgmt(1'b0, 5'h1F);
    rdc(8'h1C, 32'h0000A51F, "data_rd");
    mgmt(1'b0, 5'h03);
    rdc(8'h1C, 32'h00005AC3, "data_rd_back");
    print_verdict();
  end
endmodule : tb
